//--- design/voice_cmd_port.sv
/*
 Serial command port of the voice recorder: samples the host's select,
 clock and data pins, returns status bytes, decodes commands and runs
 the row engine for play, record and erase with a one-deep ranged queue.
 Assumes pins arrive asynchronously and the memory array logic shares CORE_CLK.
*/
module voice_cmd_port
   import voice_cmd_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire logic SS_N_PIN,
   input wire logic SCLK_PIN,
   input wire logic MOSI_PIN,
   input wire logic MEM_FULL_IN,
   input wire logic MEM_EOM_IN,
   output logic MISO,
   output logic MISO_OE,
   output logic INT_N,
   output logic LED,
   output logic MEM_PLAY,
   output logic MEM_REC,
   output logic MEM_ERASE,
   output logic MEM_EOM_WR,
   output logic [10:0] MEM_ROW
);
   logic [2:0] sync1_ff, sync2_ff, sync3_ff;
   logic ss_n, sclk, mosi, sel, ss_fall, ss_rise, sclk_rise, sclk_fall;
   logic [55:0] rx_ff, nxt_rx, tx_ff, nxt_tx;
   logic [6:0] rx_cnt_ff, nxt_rx_cnt, tx_cnt_ff, nxt_tx_cnt;
   logic miso_ff, nxt_miso, oe_ff, nxt_oe;
   logic err_ff, nxt_err, pu_ff, nxt_pu, eom_ff, nxt_eom, int_ff, nxt_int;
   logic int_n_ff, led_ff, nxt_led, led_cmd_ff, nxt_led_cmd;
   logic play_ff, rec_ff, erase_ff, eom_wr_ff, nxt_eom_wr;
   eng_state_t state_ff, nxt_state;
   mem_op_t op_ff, nxt_op, q_op_ff, nxt_q_op, go_op;
   logic ranged_ff, nxt_ranged, q_valid_ff, nxt_q_valid, go, go_ranged, stop;
   logic [10:0] cur_ff, nxt_cur, end_ff, nxt_end, q_lo_ff, nxt_q_lo, q_hi_ff, nxt_q_hi;
   logic [10:0] go_lo, go_hi, rec_ptr_ff, nxt_rec_ptr, play_ptr_ff, nxt_play_ptr;
   logic [11:0] apc_ff, nxt_apc, nv_ff, nxt_nv;
   logic [15:0] tmr_ff, nxt_tmr;
   logic [15:0] sr0;
   logic [7:0] sr1, cmd, cmd_now;
   logic row_tick, last_row, mismatch;

   // Two-flop synchronisers plus a third stage for edge finding
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         sync1_ff <= 3'h3;
         sync2_ff <= 3'h3;
         sync3_ff <= 3'h3;
      end else if (CLK_EN) begin
         sync1_ff <= {MOSI_PIN, SCLK_PIN, SS_N_PIN};
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   assign ss_n = sync2_ff[0];
   assign sclk = sync2_ff[1];
   assign mosi = sync2_ff[2];
   assign sel = ~ss_n;
   assign ss_fall = CLK_EN & sync3_ff[0] & ~ss_n;
   assign ss_rise = CLK_EN & ~sync3_ff[0] & ss_n;
   assign sclk_rise = CLK_EN & sel & ~sync3_ff[1] & sclk;
   assign sclk_fall = CLK_EN & sel & sync3_ff[1] & ~sclk;
   assign sr0 = {cur_ff, int_ff, eom_ff, pu_ff, MEM_FULL_IN, err_ff};
   assign sr1 = {7'h00, (state_ff == ST_IDLE) | ~q_valid_ff};
   assign cmd = rx_ff[7:0] & LED_MASK;
   assign row_tick = CLK_EN & (state_ff == ST_RUN) & (tmr_ff >= 16'(ROW_CYCLES - 1)) & ~ss_rise;
   assign last_row = (cur_ff == end_ff) | (op_ff == OP_PLAY & MEM_EOM_IN & ~q_valid_ff);

   always_comb begin
      nxt_rx = rx_ff;
      nxt_tx = tx_ff;
      nxt_rx_cnt = rx_cnt_ff;
      nxt_tx_cnt = tx_cnt_ff;
      nxt_miso = miso_ff;
      nxt_oe = sel;
      nxt_err = err_ff;
      nxt_pu = pu_ff;
      nxt_eom = eom_ff;
      nxt_int = int_ff;
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_q_op = q_op_ff;
      nxt_ranged = ranged_ff;
      nxt_q_valid = q_valid_ff;
      nxt_cur = cur_ff;
      nxt_end = end_ff;
      nxt_q_lo = q_lo_ff;
      nxt_q_hi = q_hi_ff;
      nxt_rec_ptr = rec_ptr_ff;
      nxt_play_ptr = play_ptr_ff;
      nxt_apc = apc_ff;
      nxt_nv = nv_ff;
      nxt_led_cmd = led_cmd_ff;
      nxt_eom_wr = 1'b0;
      nxt_tmr = (state_ff == ST_RUN) ? tmr_ff + 16'h0001 : 16'h0000;
      cmd_now = {mosi, rx_ff[6:0]} & LED_MASK;
      go = 1'b0;
      go_ranged = 1'b0;
      go_op = OP_NONE;
      go_lo = rx_ff[26:16];
      go_hi = rx_ff[42:32];
      stop = 1'b0;
      mismatch = 1'b0;
      // Load status for the return stream at the start of a transaction
      if (ss_fall) begin
         nxt_rx_cnt = 7'h00;
         nxt_tx_cnt = 7'h00;
         nxt_tx = {sr0[7:0], sr0, sr0, sr0};
      end
      if (sclk_rise && rx_cnt_ff < 7'(XFER_BITS)) begin
         nxt_rx[rx_cnt_ff[5:0]] = mosi;
         nxt_rx_cnt = rx_cnt_ff + 7'h01;
         if (rx_cnt_ff == BITS_CMD_LAST) begin
            case (cmd_now)
               CMD_RD_STATUS: nxt_tx[31:16] = {8'h00, sr1};
               CMD_RD_IDENTITY: nxt_tx[31:16] = {8'h00, DEVICE_IDENT};
               CMD_READ_RECORD_POINTER_CMD: nxt_tx[31:16] = {5'h00, rec_ptr_ff};
               CMD_READ_PLAY_POINTER_CMD: nxt_tx[31:16] = {5'h00, play_ptr_ff};
               CMD_RD_ANALOG: nxt_tx[31:16] = {4'h0, apc_ff};
               default: nxt_tx[31:16] = sr0;
            endcase
         end
      end
      if (sclk_fall) begin
         nxt_miso = (tx_cnt_ff < 7'(XFER_BITS)) ? tx_ff[tx_cnt_ff[5:0]] : 1'b0;
         if (tx_cnt_ff < 7'(XFER_BITS)) nxt_tx_cnt = tx_cnt_ff + 7'h01;
      end
      // Row engine steps one row per row time
      if (row_tick) begin
         nxt_tmr = 16'h0000;
         if (last_row) begin
            nxt_int = 1'b1;
            if (op_ff == OP_REC && ranged_ff) nxt_eom_wr = 1'b1;
            if (op_ff == OP_PLAY && MEM_EOM_IN && !q_valid_ff) nxt_eom = 1'b1;
            if (op_ff == OP_REC) nxt_rec_ptr = cur_ff + 11'h001;
            if (op_ff == OP_PLAY) nxt_play_ptr = cur_ff;
            if (q_valid_ff) begin
               nxt_cur = q_lo_ff;
               nxt_end = q_hi_ff;
               nxt_q_valid = 1'b0;
            end else begin
               nxt_state = ST_IDLE;
            end
         end else begin
            nxt_cur = cur_ff + 11'h001;
         end
      end
      // Act on commands only once select returns high; read data was already picked on the eighth bit
      if (ss_rise) begin
         nxt_err = 1'b0;
         if (rx_cnt_ff < BITS_SHORT) begin
            nxt_err = 1'b1;
         end else begin
            case (cmd)
               CMD_POWER_UP: nxt_pu = 1'b1;
               CMD_POWER_DOWN: begin
                  nxt_pu = 1'b0;
                  stop = 1'b1;
               end
               CMD_STOP: stop = 1'b1;
               CMD_RESET: begin
                  stop = 1'b1;
                  nxt_rec_ptr = ROW_RESET;
                  nxt_play_ptr = ROW_RESET;
               end
               CMD_CLEAR_INT: begin
                  nxt_int = 1'b0;
                  nxt_eom = 1'b0;
               end
               CMD_RD_STATUS, CMD_RD_IDENTITY: nxt_err = 1'b0;
               default: begin
                  if (!pu_ff) begin
                     nxt_err = 1'b1;
                  end else begin
                     case (cmd)
                        CMD_PLAY: begin
                           go = 1'b1;
                           go_op = OP_PLAY;
                           go_lo = play_ptr_ff;
                           go_hi = ROW_LAST;
                        end
                        CMD_RECORD: begin
                           go = 1'b1;
                           go_op = OP_REC;
                           go_lo = rec_ptr_ff;
                           go_hi = ROW_LAST;
                        end
                        CMD_ERASE: begin
                           go = 1'b1;
                           go_op = OP_ERASE;
                           go_lo = play_ptr_ff;
                           go_hi = play_ptr_ff;
                        end
                        CMD_GLOBAL_ERASE: begin
                           go = 1'b1;
                           go_op = OP_ERASE;
                           go_lo = ROW_FIRST_FREE;
                           go_hi = ROW_LAST;
                        end
                        CMD_FORWARD: begin
                           nxt_play_ptr = play_ptr_ff + 11'h001;
                           nxt_int = 1'b1;
                        end
                        CMD_READ_RECORD_POINTER_CMD, CMD_READ_PLAY_POINTER_CMD, CMD_RD_ANALOG: nxt_err = 1'b0;
                        CMD_WR_ANALOG: begin
                           if (rx_cnt_ff < BITS_APC) nxt_err = 1'b1;
                           else nxt_apc = rx_ff[19:8];
                        end
                        CMD_STORE_NV: nxt_nv = apc_ff;
                        CMD_LOAD_NV: nxt_apc = nv_ff;
                        CMD_CHECK_MEM: nxt_int = 1'b1;
                        CMD_RANGE_PLAY, CMD_RANGE_RECORD, CMD_RANGE_ERASE: begin
                           go = rx_cnt_ff >= BITS_RANGED;
                           go_ranged = 1'b1;
                           nxt_err = rx_cnt_ff < BITS_RANGED;
                           go_op = (cmd == CMD_RANGE_PLAY) ? OP_PLAY :
                                   (cmd == CMD_RANGE_RECORD) ? OP_REC : OP_ERASE;
                        end
                        default: nxt_err = 1'b1;
                     endcase
                  end
               end
            endcase
         end
         if (stop) begin
            nxt_state = ST_IDLE;
            nxt_q_valid = 1'b0;
         end else if (go && state_ff == ST_IDLE) begin
            nxt_state = ST_RUN;
            nxt_op = go_op;
            nxt_ranged = go_ranged;
            nxt_cur = go_lo;
            nxt_end = go_hi;
            nxt_tmr = 16'h0000;
            nxt_led_cmd = rx_ff[LED_BIT];
         end else if (go && go_ranged && ranged_ff && go_op == op_ff && !q_valid_ff) begin
            nxt_q_valid = 1'b1;
            nxt_q_lo = go_lo;
            nxt_q_hi = go_hi;
            nxt_q_op = go_op;
         end else if (go) begin
            mismatch = 1'b1;
            nxt_err = 1'b1;
         end
      end
      nxt_led = (nxt_state == ST_RUN) & nxt_led_cmd;
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         rx_ff <= '0;
         tx_ff <= '0;
         rx_cnt_ff <= 7'h00;
         tx_cnt_ff <= 7'h00;
         miso_ff <= 1'b0;
         oe_ff <= 1'b0;
         err_ff <= 1'b0;
         pu_ff <= 1'b0;
         eom_ff <= 1'b0;
         int_ff <= 1'b0;
         int_n_ff <= 1'b1;
         state_ff <= ST_IDLE;
         op_ff <= OP_NONE;
         q_op_ff <= OP_NONE;
         ranged_ff <= 1'b0;
         q_valid_ff <= 1'b0;
         cur_ff <= ROW_RESET;
         end_ff <= ROW_RESET;
         q_lo_ff <= ROW_RESET;
         q_hi_ff <= ROW_RESET;
         rec_ptr_ff <= ROW_RESET;
         play_ptr_ff <= ROW_RESET;
         apc_ff <= APC_RESET;
         nv_ff <= APC_RESET;
         tmr_ff <= 16'h0000;
         led_cmd_ff <= 1'b0;
         led_ff <= 1'b0;
         play_ff <= 1'b0;
         rec_ff <= 1'b0;
         erase_ff <= 1'b0;
         eom_wr_ff <= 1'b0;
      end else if (CLK_EN) begin
         rx_ff <= nxt_rx;
         tx_ff <= nxt_tx;
         rx_cnt_ff <= nxt_rx_cnt;
         tx_cnt_ff <= nxt_tx_cnt;
         miso_ff <= nxt_miso;
         oe_ff <= nxt_oe;
         err_ff <= nxt_err;
         pu_ff <= nxt_pu;
         eom_ff <= nxt_eom;
         int_ff <= nxt_int;
         int_n_ff <= ~nxt_int;
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         q_op_ff <= nxt_q_op;
         ranged_ff <= nxt_ranged;
         q_valid_ff <= nxt_q_valid;
         cur_ff <= nxt_cur;
         end_ff <= nxt_end;
         q_lo_ff <= nxt_q_lo;
         q_hi_ff <= nxt_q_hi;
         rec_ptr_ff <= nxt_rec_ptr;
         play_ptr_ff <= nxt_play_ptr;
         apc_ff <= nxt_apc;
         nv_ff <= nxt_nv;
         tmr_ff <= nxt_tmr;
         led_cmd_ff <= nxt_led_cmd;
         led_ff <= nxt_led;
         play_ff <= (nxt_state == ST_RUN) & (nxt_op == OP_PLAY);
         rec_ff <= (nxt_state == ST_RUN) & (nxt_op == OP_REC);
         erase_ff <= (nxt_state == ST_RUN) & (nxt_op == OP_ERASE);
         eom_wr_ff <= nxt_eom_wr;
      end
   end

   assign MISO = miso_ff;
   assign MISO_OE = oe_ff;
   assign INT_N = int_n_ff;
   assign LED = led_ff;
   assign MEM_PLAY = play_ff;
   assign MEM_REC = rec_ff;
   assign MEM_ERASE = erase_ff;
   assign MEM_EOM_WR = eom_wr_ff;
   assign MEM_ROW = cur_ff;

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   sequence s_last_row;
      row_tick && last_row;
   endsequence
   sequence s_done_alone;
      s_last_row ##0 !q_valid_ff;
   endsequence
   sequence s_done_chained;
      s_last_row ##0 q_valid_ff;
   endsequence

   property p_miso_on_fall;
      $changed(miso_ff) |-> $past(sclk_fall);
   endproperty
   a_miso_on_fall: assert property (p_miso_on_fall) else $error("MISO moved off a falling edge");
   property p_status_first;
      ss_fall |=> tx_ff[15:0] == $past(sr0) && tx_cnt_ff == 7'h00;
   endproperty
   a_status_first: assert property (p_status_first) else $error("status not loaded first");
   property p_status_repeat;
      ss_fall |=> tx_ff[55:32] == {$past(sr0[7:0]), $past(sr0)};
   endproperty
   a_status_repeat: assert property (p_status_repeat) else $error("status repeat wrong");
   property p_int_pin;
      int_n_ff == !sr0[SR0_INT];
   endproperty
   a_int_pin: assert property (p_int_pin) else $error("interrupt pin disagrees");
   property p_refuse_mix;
      mismatch |=> sr0[SR0_ERR] && $stable(q_valid_ff);
   endproperty
   a_refuse_mix: assert property (p_refuse_mix) else $error("mixed ranged not refused");
   property p_stop_at_end;
      s_done_alone |=> state_ff == ST_IDLE && sr0[SR0_INT] ##1 !play_ff && !rec_ff;
   endproperty
   a_stop_at_end: assert property (p_stop_at_end) else $error("engine ran past end");
   property p_chain;
      s_done_chained |=> state_ff == ST_RUN && cur_ff == $past(q_lo_ff) && !q_valid_ff;
   endproperty
   a_chain: assert property (p_chain) else $error("queued command not taken");
   property p_done_int;
      s_last_row |=> int_ff ##1 !int_n_ff;
   endproperty
   a_done_int: assert property (p_done_int) else $error("no interrupt at completion");
   property p_rec_marker;
      s_last_row ##0 (op_ff == OP_REC && ranged_ff) |=> eom_wr_ff ##1 !eom_wr_ff;
   endproperty
   a_rec_marker: assert property (p_rec_marker) else $error("no END_OF_MESSAGE_FLAG at record end");
   property p_start_on_rise;
      $rose(state_ff == ST_RUN) |-> $past(ss_rise);
   endproperty
   a_start_on_rise: assert property (p_start_on_rise) else $error("started mid transaction");
endmodule

//--- design/voice_cmd_pkg.sv
/*
 Shared constants for the serial command port of the voice recorder:
 opcodes, status word layout, transfer lengths, row limits and timing.
 Assumes a 100 MHz core clock and a host that acts as serial master.
*/
package voice_cmd_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ROW_TIME_NS = 1000;
   localparam int ROW_CYCLES = (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XFER_BITS = 56;
   localparam logic [6:0] BITS_SHORT = 7'h10;
   localparam logic [6:0] BITS_APC = 7'h18;
   localparam logic [6:0] BITS_RANGED = 7'h38;
   localparam logic [6:0] BITS_CMD_LAST = 7'h07;
   localparam int LED_BIT = 4;
   localparam logic [7:0] LED_MASK = 8'hef;
   // Status word zero bit positions
   localparam int SR0_ERR = 0;
   localparam int SR0_FULL = 1;
   localparam int SR0_PU = 2;
   localparam int SR0_EOM = 3;
   localparam int SR0_INT = 4;
   localparam int SR0_ROW = 5;
   // Opcodes with the LED bit cleared
   localparam logic [7:0] CMD_POWER_UP = 8'h01;
   localparam logic [7:0] CMD_STOP = 8'h02;
   localparam logic [7:0] CMD_RESET = 8'h03;
   localparam logic [7:0] CMD_CLEAR_INT = 8'h04;
   localparam logic [7:0] CMD_RD_STATUS = 8'h05;
   localparam logic [7:0] CMD_POWER_DOWN = 8'h07;
   localparam logic [7:0] CMD_RD_IDENTITY = 8'h09;
   localparam logic [7:0] CMD_PLAY = 8'h40;
   localparam logic [7:0] CMD_RECORD = 8'h41;
   localparam logic [7:0] CMD_ERASE = 8'h42;
   localparam logic [7:0] CMD_GLOBAL_ERASE = 8'h43;
   localparam logic [7:0] CMD_FORWARD = 8'h48;
   localparam logic [7:0] CMD_READ_RECORD_POINTER_CMD = 8'h06;
   localparam logic [7:0] CMD_READ_PLAY_POINTER_CMD = 8'h08;
   localparam logic [7:0] CMD_RD_ANALOG = 8'h44;
   localparam logic [7:0] CMD_WR_ANALOG = 8'h45;
   localparam logic [7:0] CMD_STORE_NV = 8'h46;
   localparam logic [7:0] CMD_LOAD_NV = 8'h47;
   localparam logic [7:0] CMD_CHECK_MEM = 8'h49;
   localparam logic [7:0] CMD_RANGE_PLAY = 8'h80;
   localparam logic [7:0] CMD_RANGE_RECORD = 8'h81;
   localparam logic [7:0] CMD_RANGE_ERASE = 8'h82;
   // Rows and reset values
   localparam logic [10:0] ROW_FIRST_FREE = 11'h010;
   localparam logic [10:0] ROW_LAST = 11'h7ff;
   localparam logic [10:0] ROW_RESET = 11'h010;
   localparam logic [11:0] APC_RESET = 12'h000;
   // Identity byte, value arbitrary
   localparam logic [7:0] DEVICE_IDENT = 8'h5a;
   typedef enum logic [1:0] {OP_NONE, OP_PLAY, OP_REC, OP_ERASE} mem_op_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} eng_state_t;
endpackage

//--- tb/spi_host_model.sv
/*
 Host model: serial master that shifts one 56-bit stream per call.
 Assumes the bench calls xfer and that done marks a finished stream.
*/
module spi_host_model (
   output logic ss_n,
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   output logic [55:0] rx,
   output logic done
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      ss_n = 1'b1;
      sclk = 1'b1;
      mosi = 1'b0;
      rx = '0;
      done = 1'b0;
   end
   // Link clock of 125 ns, still outside frames
   task automatic xfer(input logic [55:0] tx);
      int i;
      ss_n = 1'b0;
      #100;
      for (i = 0; i < 56; i++) begin
         sclk = 1'b0;
         mosi = tx[i];
         #62.5;
         sclk = 1'b1;
         rx[i] = miso;
         #62.5;
      end
      mosi = 1'b0;
      ss_n = 1'b1;
      #100;
      done = 1'b1;
      #10;
      done = 1'b0;
   endtask
endmodule

//--- tb/tb.sv
/*
 Bench for the voice command port: host model, note queue, checks.
 Assumes the package and the design are compiled first.
*/
module tb
   import voice_cmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {logic [55:0] e; logic [55:0] m;} note_t;
   note_t notes[$];
   logic core_clk, sys_rst, clk_en, full_in, eom_in, done;
   logic ss_n, sclk, mosi, miso, miso_oe, int_n, led;
   logic m_play, m_rec, m_erase, m_eomwr;
   logic [10:0] m_row, s, e, b, r;
   logic [11:0] a;
   logic [55:0] rx;
   int miscompares, checked;
   int seed = 32'hed89ad81;
   voice_cmd_port dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
      .SS_N_PIN(ss_n), .SCLK_PIN(sclk), .MOSI_PIN(mosi), .MEM_FULL_IN(full_in),
      .MEM_EOM_IN(eom_in), .MISO(miso), .MISO_OE(miso_oe), .INT_N(int_n), .LED(led),
      .MEM_PLAY(m_play), .MEM_REC(m_rec), .MEM_ERASE(m_erase), .MEM_EOM_WR(m_eomwr),
      .MEM_ROW(m_row));
   spi_host_model host (.ss_n(ss_n), .sclk(sclk), .mosi(mosi), .miso(miso), .rx(rx),
      .done(done));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [15:0] st(input logic er, pu, it, input logic [10:0] row);
      return {row, it, 1'b0, pu, full_in, er};
   endfunction
   function automatic logic [55:0] rng(input logic [7:0] c, input logic [10:0] a, z);
      return {13'h0, z, 5'h0, a, 8'h0, c};
   endfunction
   task automatic chk(input string nm, input logic [55:0] ex, input logic [55:0] got);
      checked++;
      if (got !== ex) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic send(input logic [55:0] tx, input logic [15:0] sw, dat, sm, dm);
      notes.push_back('{{sw[7:0], sw, dat, sw}, {sm[7:0], sm, dm, sm}});
      host.xfer(tx);
   endtask
   task automatic echo(input logic [55:0] tx, input logic [15:0] sw, sm);
      send(tx, sw, sw, sm, sm);
   endtask
   // Each finished stream is matched against the oldest note
   always @(posedge done) begin
      note_t n;
      n = notes.pop_front();
      chk("miso stream", n.e & n.m, rx & n.m);
   end
   function automatic logic hit(input int sel);
      case (sel)
         0: return m_play === 1'b1;
         1: return int_n === 1'b0;
         2: return m_eomwr === 1'b1;
         3: return (m_erase === 1'b1 || m_play === 1'b1) && m_row === b;
         default: return m_erase === 1'b0 && m_play === 1'b0;
      endcase
   endfunction
   task automatic wait_for(input int sel, input int lim);
      int k;
      for (k = 0; k < lim; k++) begin
         @(posedge core_clk);
         #1;
         if (hit(sel)) return;
      end
      miscompares++;
      $display("unexpected wait %0d expected 1 seen 0", sel);
      report_and_stop();
   endtask
   task automatic report_and_stop();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      full_in = 1'b0;
      eom_in = 1'b0;
      miscompares = 0;
      checked = 0;
      repeat (3) @(posedge core_clk);
      full_in <= 1'($random(seed));
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("int_n", 1'b1, int_n);
      chk("row", ROW_RESET, m_row);
      chk("miso_oe", 1'b0, miso_oe);
      chk("led", 1'b0, led);
      send(56'(CMD_RD_STATUS), st(0, 0, 0, ROW_RESET), 16'h0001, 16'hffff, 16'hffff);
      echo(56'(CMD_PLAY), st(0, 0, 0, ROW_RESET), 16'hffff);
      echo(56'(CMD_POWER_UP), st(1, 0, 0, ROW_RESET), 16'hffff);
      send(56'(CMD_RD_IDENTITY), st(0, 1, 0, ROW_RESET), {8'h00, DEVICE_IDENT},
         16'hffff, 16'hffff);
      $display("test priority done");
      s = {7'h0, 4'($random(seed))};
      e = s + 11'd15;
      echo(rng(CMD_RANGE_PLAY | 8'h10, s, e), st(0, 1, 0, ROW_RESET), 16'hffff);
      wait_for(0, 20);
      chk("play row", s, m_row);
      chk("led", 1'b1, led);
      echo(rng(CMD_RANGE_ERASE, s, e), st(0, 1, 0, s), 16'h001f);
      chk("erase", 1'b0, m_erase);
      wait_for(1, 2000);
      chk("end row", e, m_row);
      chk("play", 1'b0, m_play);
      chk("led", 1'b0, led);
      echo(56'(CMD_CLEAR_INT), st(1, 1, 1, e), 16'hfff7);
      chk("int_n", 1'b1, int_n);
      $display("test ranged play done");
      r = 11'($random(seed));
      echo(rng(CMD_RANGE_RECORD, r, r), st(0, 1, 0, e), 16'hffff);
      chk("rec", 1'b1, m_rec);
      wait_for(2, 300);
      chk("eom row", r, m_row);
      $display("test record done");
      a = 12'($random(seed));
      echo(56'({a, CMD_WR_ANALOG}), st(0, 1, 1, r), 16'hffff);
      echo(56'(CMD_STORE_NV), st(0, 1, 1, r), 16'hffff);
      echo(56'({~a, CMD_WR_ANALOG}), st(0, 1, 1, r), 16'hffff);
      echo(56'(CMD_LOAD_NV), st(0, 1, 1, r), 16'hffff);
      send(56'(CMD_RD_ANALOG), st(0, 1, 1, r), {4'h0, a}, 16'hffff, 16'hffff);
      echo(56'(CMD_RESET), st(0, 1, 1, r), 16'hffff);
      echo(56'(CMD_FORWARD), st(0, 1, 1, r), 16'hffff);
      a = 12'(ROW_RESET) + 12'h001;
      send(56'(CMD_READ_PLAY_POINTER_CMD), st(0, 1, 1, r), {4'h0, a}, 16'hffff, 16'hffff);
      send(56'(CMD_READ_RECORD_POINTER_CMD), st(0, 1, 1, r), {5'h00, ROW_RESET}, 16'hffff, 16'hffff);
      echo(56'(CMD_POWER_DOWN), st(0, 1, 1, r), 16'hffff);
      echo(56'(CMD_CHECK_MEM), st(0, 0, 1, r), 16'hffff);
      echo(56'(CMD_POWER_UP), st(1, 0, 1, r), 16'hffff);
      $display("test config done");
      s = {1'b0, 10'($random(seed))};
      e = s + 11'd14;
      b = e + 11'd40;
      echo(rng(CMD_RANGE_ERASE, s, e), st(0, 1, 1, r), 16'hfff7);
      echo(rng(CMD_RANGE_ERASE, b, b), st(0, 1, 1, r), 16'h0017);
      send(56'(CMD_RD_STATUS), st(0, 1, 1, r), 16'h0000, 16'h0017, 16'hffff);
      wait_for(3, 1000);
      chk("queued row", b, m_row);
      wait_for(4, 300);
      $display("test queue done");
      echo(56'(CMD_CLEAR_INT), st(0, 1, 1, b), 16'hffff);
      echo(rng(CMD_RANGE_PLAY, s, e), st(0, 1, 0, b), 16'hffff);
      echo(rng(CMD_RANGE_PLAY, b, b), st(0, 1, 0, s), 16'h001f);
      @(posedge core_clk);
      eom_in <= 1'b1;
      wait_for(3, 1500);
      chk("chain play", 1'b1, m_play);
      wait_for(4, 300);
      chk("led", 1'b0, led);
      echo(56'(CMD_CLEAR_INT), st(0, 1, 1, b) | (16'h0001 << SR0_EOM), 16'hffff);
      $display("test eom chain done");
      report_and_stop();
   end
endmodule
